// ---- pkg/sio_pkg.sv ----
package sio_pkg;
  // register addresses at the default base; the high nibble is matched to the base jumpers
  localparam logic [7:0] REG_LIST_STAT = 8'h80;
  localparam logic [7:0] REG_LIST_DATA = 8'h81;
  localparam logic [7:0] REG_CON_STAT  = 8'h82;
  localparam logic [7:0] REG_CON_DATA  = 8'h83;
  localparam logic [7:0] REG_TMR_A     = 8'h84;
  localparam logic [7:0] REG_TMR_B     = 8'h88;
  localparam logic [7:0] REG_PAR       = 8'h8D;
  localparam logic [3:0] OFS_LIST      = REG_LIST_STAT[3:0];
  localparam logic [3:0] OFS_CON       = REG_CON_STAT[3:0];
  localparam logic [3:0] OFS_TMR_A     = REG_TMR_A[3:0];
  localparam logic [3:0] OFS_TMR_B     = REG_TMR_B[3:0];
  localparam logic [3:0] OFS_PAR       = REG_PAR[3:0];
  localparam logic [1:0] CTL_IDX       = 2'h3;
  // timer clock
  localparam int         SYS_HZ        = 40_000_000;
  localparam int         TMR_HZ        = 2_000_000;
  localparam logic [4:0] PRE_LAST      = 5'(SYS_HZ / TMR_HZ - 1);
  localparam int         NUM_CTR       = 6;
  localparam int         CTR_PER_CHIP  = 3;
  localparam int         RTC_FIRST     = 3;
  // counter control word
  localparam int         CW_BCD        = 0;
  localparam int         CW_MODE_LSB   = 1;
  localparam int         CW_SEL_LSB    = 6;
  localparam logic [2:0] MODE_SQ       = 3'h3;
  localparam logic [3:0] BCD_MAX       = 4'h9;
  // serial mode and command words
  localparam int         MD_LEN_LSB    = 2;
  localparam int         MD_PEN        = 4;
  localparam int         MD_EVEN       = 5;
  localparam int         MD_STOP_LSB   = 6;
  localparam logic [1:0] STOP_15       = 2'h2;
  localparam logic [1:0] STOP_2        = 2'h3;
  localparam int         CMD_TXEN      = 0;
  localparam int         CMD_RXEN      = 2;
  localparam int         CMD_ERST      = 4;
  localparam int         CMD_IRST      = 6;
  localparam logic [2:0] LEN_BASE      = 3'h4;
  localparam logic [2:0] LAST_MAX      = 3'h7;
  // bit times in 16x ticks
  localparam logic [5:0] TK_BIT        = 6'h10;
  localparam logic [5:0] TK_HALF       = 6'h08;
  localparam logic [5:0] TK_STOP15     = 6'h18;
  localparam logic [5:0] TK_STOP2      = 6'h20;
  localparam int         TXQ_DEPTH     = 8;
endpackage

// ---- rtl/sio_board.sv ----
// Operation
// - two serial ports, one parallel output, six 16-bit counters on the bus.
// - parallel output is an 8-bit latch holding the last written byte.
// - counters 0 and 1 clock the serial ports; four stay free.
// - serial ports flag parity, overrun, framing; 1/1.5/2 stops; reject false starts.
// - offsets 0/1 list status/data, 2/3 console status/data.
// - writes to offset D load the parallel latch.
// - reads at offset D return the optional parallel input when fitted.
// - base nibble comes from four jumpers, fitted means one.
// - seven jumpers give vector bits 7..1, absent means one.
// - vector bit 0 is always zero.
// - interrupt enable jumper gates the interrupt request.
// - shipped with interrupts enabled and vector 10 hex.
// - two free counters chain from 2 MHz into a one-second pulse.
// - the last two free counters accumulate seconds for the host.
// - only the last counter's output (counter 5) raises the interrupt request.
// - console transmitter starts a character only while clear-to-send is asserted.
// - printer busy on list clear-to-send pauses transmission.
// - on the serial ports, even offset is control/status, odd offset is data.
// - a serial port ignores strobes and drives nothing unless selected.
`timescale 1ns/1ps

module sio_fifo #(
  parameter int W = 8,
  parameter int D = 8
) (
  input  wire logic         clk_sys,
  input  wire logic         srst,
  input  wire logic         ce,
  input  wire logic         in_valid,
  input  wire logic [W-1:0] in_data,
  output logic              in_ready,
  output logic              out_valid,
  output logic      [W-1:0] out_data,
  input  wire logic         out_ready
);
  localparam int AW = $clog2(D);
  logic [W-1:0] mem [D];
  logic [AW-1:0] wp_q;
  logic [AW-1:0] rp_q;
  logic [AW:0]   cnt_q;
  wire push = in_valid & in_ready & ce;
  wire pop  = out_valid & out_ready & ce;
  assign in_ready  = cnt_q != (AW+1)'(D);
  assign out_valid = cnt_q != '0;
  assign out_data  = mem[rp_q];

  always_ff @(posedge clk_sys)
  begin
    if (push)
      mem[wp_q] <= in_data;
  end

  always_ff @(posedge clk_sys)
  begin
    if (srst)
    begin
      wp_q  <= '0;
      rp_q  <= '0;
      cnt_q <= '0;
    end
    else
    begin
      if (push)
        wp_q <= wp_q + 1'b1;
      if (pop)
        rp_q <= rp_q + 1'b1;
      cnt_q <= cnt_q + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
endmodule

module sio_ctr
  import sio_pkg::*;
(
  input  wire logic       clk_sys,
  input  wire logic       srst,
  input  wire logic       ce,
  input  wire logic       tick,
  input  wire logic       wr_cnt,
  input  wire logic       wr_ctl,
  input  wire logic       rd,
  input  wire logic [7:0] wdata,
  output logic      [7:0] rdata,
  output logic            out
);
  logic [15:0] rl_q;
  logic [15:0] cnt_q;
  logic [2:0]  md_q;
  logic        bcd_q;
  logic        whi_q;
  logic        rhi_q;
  logic        run_q;
  logic        out_q;

  function automatic logic [15:0] dec1(input logic [15:0] x, input logic b);
    logic [15:0] r;
    logic        br;
    r  = x - 16'h0001;
    br = 1'b1;
    if (b)
    begin
      r = x;
      for (int n = 0; n < 4; n++)
        if (br)
        begin
          if (r[4*n+:4] == 4'h0)
            r[4*n+:4] = BCD_MAX;
          else
          begin
            r[4*n+:4] = r[4*n+:4] - 4'h1;
            br = 1'b0;
          end
        end
    end
    return r;
  endfunction

  // square wave steps by two so the output period equals the count rounded up to even
  wire        sq   = md_q == MODE_SQ;
  wire [15:0] d1   = dec1(cnt_q, bcd_q);
  wire [15:0] nxt  = sq ? dec1(d1, bcd_q) : d1;
  wire        term = sq ? (cnt_q == 16'h0001 || cnt_q == 16'h0002) : cnt_q == 16'h0001;
  wire        csq  = wdata[CW_MODE_LSB+:3] == MODE_SQ;
  assign rdata = rhi_q ? cnt_q[15:8] : cnt_q[7:0];
  assign out   = out_q;

  always_ff @(posedge clk_sys)
  begin
    if (srst)
    begin
      {rl_q, cnt_q, md_q} <= '0;
      {bcd_q, whi_q, rhi_q, run_q, out_q} <= '0;
    end
    else if (ce)
    begin
      if (wr_ctl)
      begin
        md_q  <= wdata[CW_MODE_LSB+:3];
        bcd_q <= wdata[CW_BCD];
        whi_q <= 1'b0;
        rhi_q <= 1'b0;
        run_q <= 1'b0;
        out_q <= csq;
      end
      else if (wr_cnt)
      begin
        whi_q <= ~whi_q;
        if (!whi_q)
          rl_q[7:0] <= wdata;
        else
        begin
          rl_q[15:8] <= wdata;
          cnt_q      <= {wdata, rl_q[7:0]};
          run_q      <= 1'b1;
          out_q      <= sq;
        end
      end
      else if (run_q && tick)
      begin
        cnt_q <= (sq && term) ? rl_q : nxt;
        if (term)
          out_q <= sq ? ~out_q : 1'b1;
      end
      if (rd)
        rhi_q <= ~rhi_q;
    end
  end

  chk_ctr_reload: assert property (@(posedge clk_sys) disable iff (srst)
    (ce && run_q && tick && sq && term && !wr_ctl && !wr_cnt) |=> cnt_q == $past(rl_q))
    else $error("square wave counter did not reload");
endmodule

module sio_uart
  import sio_pkg::*;
(
  input  wire logic       clk_sys,
  input  wire logic       srst,
  input  wire logic       ce,
  input  wire logic       baud_tick,
  input  wire logic       sel,
  input  wire logic       c_d,
  input  wire logic       wr_stb,
  input  wire logic       rd_stb,
  input  wire logic [7:0] wdata,
  input  wire logic       rxd,
  input  wire logic       cts_n,
  output logic      [7:0] rdata,
  output logic            txd
);
  typedef enum logic [2:0] {SIO_IDLE, SIO_START, SIO_DATA, SIO_PAR, SIO_STOP} sio_bit_t;
  sio_bit_t   tx_q;
  sio_bit_t   rx_q;
  logic [7:0] mode_q, cmd_q, txsh_q, rxsh_q, rbuf_q;
  logic       expect_mode_q, rxrdy_q, pe_q, oe_q, fe_q, txd_q, txpar_q, rpar_q;
  logic [5:0] ttk_q, rtk_q;
  logic [2:0] tbit_q, rbit_q;
  logic       f_valid, f_ready;
  logic [7:0] f_data;

  wire       acc_wr   = sel & wr_stb & ce;
  wire       acc_rd   = sel & rd_stb & ce;
  wire       rd_data  = acc_rd & ~c_d;
  wire       err_clr  = acc_wr & c_d & ~expect_mode_q & wdata[CMD_ERST];
  wire [2:0] last_bit = LEN_BASE + 3'(mode_q[MD_LEN_LSB+:2]);
  wire [7:0] dmask    = 8'hFF >> (LAST_MAX - last_bit);
  wire       pen      = mode_q[MD_PEN];
  wire       even     = mode_q[MD_EVEN];
  wire [1:0] stp      = mode_q[MD_STOP_LSB+:2];
  wire [5:0] stop_tk  = stp == STOP_2 ? TK_STOP2 : stp == STOP_15 ? TK_STOP15 : TK_BIT;
  // a character under way is finished even if clear-to-send drops
  wire       tx_go    = tx_q == SIO_IDLE & f_valid & cmd_q[CMD_TXEN] & ~cts_n;
  wire [5:0] tx_lim   = tx_q == SIO_STOP ? stop_tk : TK_BIT;
  wire       tx_end   = baud_tick & (ttk_q == tx_lim - 6'h01);
  wire [5:0] rx_lim   = rx_q == SIO_START ? TK_HALF : TK_BIT;
  wire       rx_mid   = baud_tick & (rtk_q == rx_lim - 6'h01);
  wire [7:0] rx_data  = rxsh_q >> (LAST_MAX - last_bit);
  wire       rx_done  = rx_mid & (rx_q == SIO_STOP);
  wire       par_exp  = (^rx_data) ^ ~even;
  wire       txrdy    = f_ready & cmd_q[CMD_TXEN] & ~cts_n;
  wire       txempty  = (tx_q == SIO_IDLE) & ~f_valid;
  assign rdata = c_d ? {2'b00, fe_q, oe_q, pe_q, txempty, rxrdy_q, txrdy} : rbuf_q;
  assign txd   = txd_q;

  // host bytes queue here; a write while full is dropped, txrdy warns first
  sio_fifo #(.W(8), .D(TXQ_DEPTH)) u_txq (
    .clk_sys   (clk_sys),
    .srst      (srst),
    .ce        (ce),
    .in_valid  (acc_wr & ~c_d),
    .in_data   (wdata),
    .in_ready  (f_ready),
    .out_valid (f_valid),
    .out_data  (f_data),
    .out_ready (tx_go)
  );

  always_ff @(posedge clk_sys)
  begin
    if (srst)
    begin
      expect_mode_q <= 1'b1;
      mode_q        <= '0;
      cmd_q         <= '0;
    end
    else if (acc_wr && c_d)
    begin
      if (expect_mode_q)
      begin
        mode_q        <= wdata;
        expect_mode_q <= 1'b0;
      end
      else
      begin
        cmd_q         <= wdata[CMD_IRST] ? '0 : wdata;
        expect_mode_q <= wdata[CMD_IRST];
      end
    end
  end

  always_ff @(posedge clk_sys)
  begin
    if (srst)
    begin
      tx_q <= SIO_IDLE;
      {ttk_q, tbit_q, txsh_q, txpar_q} <= '0;
      txd_q <= 1'b1;
    end
    else if (ce)
    begin
      if (baud_tick)
        ttk_q <= ttk_q + 6'h01;
      if (tx_end)
        ttk_q <= '0;
      unique case (tx_q)
        SIO_IDLE:
          if (tx_go)
          begin
            tx_q    <= SIO_START;
            txsh_q  <= f_data;
            txpar_q <= (^(f_data & dmask)) ^ ~even;
            ttk_q   <= '0;
            tbit_q  <= '0;
            txd_q   <= 1'b0;
          end
        SIO_START:
          if (tx_end)
          begin
            tx_q  <= SIO_DATA;
            txd_q <= txsh_q[0];
          end
        SIO_DATA:
          if (tx_end)
          begin
            if (tbit_q == last_bit)
            begin
              tx_q  <= pen ? SIO_PAR : SIO_STOP;
              txd_q <= pen ? txpar_q : 1'b1;
            end
            else
            begin
              tbit_q <= tbit_q + 3'h1;
              txsh_q <= txsh_q >> 1;
              txd_q  <= txsh_q[1];
            end
          end
        SIO_PAR:
          if (tx_end)
          begin
            tx_q  <= SIO_STOP;
            txd_q <= 1'b1;
          end
        SIO_STOP:
          if (tx_end)
            tx_q <= SIO_IDLE;
      endcase
    end
  end

  // status flags: a completing character wins over a clearing access
  always_ff @(posedge clk_sys)
  begin
    if (srst)
    begin
      rx_q <= SIO_IDLE;
      {rtk_q, rbit_q, rxsh_q, rbuf_q, rpar_q} <= '0;
      {rxrdy_q, pe_q, oe_q, fe_q} <= '0;
    end
    else if (ce)
    begin
      if (baud_tick)
        rtk_q <= rtk_q + 6'h01;
      if (rd_data)
        rxrdy_q <= 1'b0;
      if (err_clr)
        {pe_q, oe_q, fe_q} <= '0;
      unique case (rx_q)
        SIO_IDLE:
          if (cmd_q[CMD_RXEN] && !rxd)
          begin
            rx_q  <= SIO_START;
            rtk_q <= '0;
          end
        SIO_START:
          if (rx_mid)
          begin
            rx_q   <= rxd ? SIO_IDLE : SIO_DATA;
            rtk_q  <= '0;
            rbit_q <= '0;
          end
        SIO_DATA:
          if (rx_mid)
          begin
            rxsh_q <= {rxd, rxsh_q[7:1]};
            rtk_q  <= '0;
            rbit_q <= rbit_q + 3'h1;
            if (rbit_q == last_bit)
              rx_q <= pen ? SIO_PAR : SIO_STOP;
          end
        SIO_PAR:
          if (rx_mid)
          begin
            rpar_q <= rxd;
            rx_q   <= SIO_STOP;
            rtk_q  <= '0;
          end
        SIO_STOP:
          if (rx_mid)
          begin
            rx_q    <= SIO_IDLE;
            rbuf_q  <= rx_data;
            rxrdy_q <= 1'b1;
            if (rxrdy_q && !rd_data)
              oe_q <= 1'b1;
            if (!rxd)
              fe_q <= 1'b1;
            if (pen && rpar_q != par_exp)
              pe_q <= 1'b1;
          end
      endcase
    end
  end

  chk_cts_gate: assert property (@(posedge clk_sys) disable iff (srst)
    (tx_q == SIO_IDLE ##1 tx_q == SIO_START) |-> $past(!cts_n && cmd_q[CMD_TXEN]))
    else $error("character started without clear-to-send");
  chk_false_start: assert property (@(posedge clk_sys) disable iff (srst)
    (ce && rx_q == SIO_START && rx_mid && rxd) |=> rx_q == SIO_IDLE)
    else $error("false start bit not rejected");
  chk_overrun_flag: assert property (@(posedge clk_sys) disable iff (srst)
    (ce && rx_done && rxrdy_q && !rd_data) |=> oe_q && rxrdy_q)
    else $error("overrun not flagged");
  chk_unsel_ignore: assert property (@(posedge clk_sys) disable iff (srst)
    !sel |=> $stable(cmd_q) && $stable(mode_q))
    else $error("unselected port changed its setup");
endmodule

module sio_board
  import sio_pkg::*;
(
  input  wire logic       clk_sys,
  input  wire logic       srst,
  input  wire logic       ce,
  input  wire logic [7:0] io_addr,
  input  wire logic       io_wr_stb,
  input  wire logic       io_rd_stb,
  input  wire logic [7:0] io_wdata,
  output logic      [7:0] io_rdata,
  output logic            io_doe,
  input  wire logic [3:0] base_jumper,
  input  wire logic [6:0] vec_absent,
  input  wire logic       interrupt_enable_jumper,
  input  wire logic       rtc_chain,
  input  wire logic       par_in_fitted,
  input  wire logic [7:0] par_in,
  output logic      [7:0] par_out,
  input  wire logic       list_rxd,
  input  wire logic       list_cts_n,
  output logic            list_txd,
  input  wire logic       con_rxd,
  input  wire logic       con_cts_n,
  output logic            con_txd,
  output logic      [5:0] tmr_out,
  output logic            intr_req,
  output logic      [7:0] intr_vector
);
  logic [4:0] pre_q;
  logic [5:0] out_prev_q;
  logic [7:0] par_q, rdata_q, vec_q;
  logic       doe_q, intr_q;
  logic [7:0] list_rd, con_rd;
  logic [7:0] ctr_rd [NUM_CTR];

  wire       hit_base = io_addr[7:4] == base_jumper;
  wire [3:0] ofs      = io_addr[3:0];
  wire       sel_list = hit_base & (ofs[3:1] == OFS_LIST[3:1]);
  wire       sel_con  = hit_base & (ofs[3:1] == OFS_CON[3:1]);
  wire [1:0] sel_tmr  = {hit_base & (ofs[3:2] == OFS_TMR_B[3:2]),
                         hit_base & (ofs[3:2] == OFS_TMR_A[3:2])};
  wire       sel_par  = hit_base & (ofs == OFS_PAR);
  wire       c_d      = ~ofs[0];
  wire       rd_tmr   = (|sel_tmr) & (ofs[1:0] != CTL_IDX);
  wire [2:0] ctr_idx  = 3'(ofs[1:0]) + (sel_tmr[1] ? 3'(CTR_PER_CHIP) : 3'h0);
  wire       rd_hit   = sel_list | sel_con | rd_tmr | (sel_par & par_in_fitted);
  wire       tick2m   = pre_q == PRE_LAST;
  wire [5:0] ctr_out;
  wire [5:0] out_rise = ctr_out & ~out_prev_q;
  wire [5:0] chain_in = {out_rise[4:0], 1'b0};
  wire [7:0] rdata_d  = sel_list ? list_rd :
                        sel_con  ? con_rd :
                        rd_tmr   ? ctr_rd[ctr_idx] :
                        par_in;

  assign io_rdata    = rdata_q;
  assign io_doe      = doe_q;
  assign par_out     = par_q;
  assign tmr_out     = ctr_out;
  assign intr_req    = intr_q;
  assign intr_vector = vec_q;

  genvar i;
  for (i = 0; i < NUM_CTR; i++)
  begin : g_ctr
    localparam logic [1:0] IDX = 2'(i % CTR_PER_CHIP);
    wire tsel = sel_tmr[i / CTR_PER_CHIP] & (ofs[1:0] == IDX);
    wire csel = sel_tmr[i / CTR_PER_CHIP] & (ofs[1:0] == CTL_IDX)
              & (io_wdata[CW_SEL_LSB+:2] == IDX);
    // upper free counters count the carry of the one below
    wire tk   = (i >= RTC_FIRST && rtc_chain) ? chain_in[i] : tick2m;
    sio_ctr u_ctr (
      .clk_sys (clk_sys),
      .srst    (srst),
      .ce      (ce),
      .tick    (tk),
      .wr_cnt  (io_wr_stb & tsel),
      .wr_ctl  (io_wr_stb & csel),
      .rd      (io_rd_stb & tsel),
      .wdata   (io_wdata),
      .rdata   (ctr_rd[i]),
      .out     (ctr_out[i])
    );
  end

  // counters 0 and 1 are the 16x baud clocks
  sio_uart u_list (
    .clk_sys   (clk_sys),
    .srst      (srst),
    .ce        (ce),
    .baud_tick (out_rise[0]),
    .sel       (sel_list),
    .c_d       (c_d),
    .wr_stb    (io_wr_stb),
    .rd_stb    (io_rd_stb),
    .wdata     (io_wdata),
    .rxd       (list_rxd),
    .cts_n     (list_cts_n),
    .rdata     (list_rd),
    .txd       (list_txd)
  );

  sio_uart u_con (
    .clk_sys   (clk_sys),
    .srst      (srst),
    .ce        (ce),
    .baud_tick (out_rise[1]),
    .sel       (sel_con),
    .c_d       (c_d),
    .wr_stb    (io_wr_stb),
    .rd_stb    (io_rd_stb),
    .wdata     (io_wdata),
    .rxd       (con_rxd),
    .cts_n     (con_cts_n),
    .rdata     (con_rd),
    .txd       (con_txd)
  );

  always_ff @(posedge clk_sys)
  begin
    if (srst)
    begin
      {pre_q, out_prev_q, par_q, rdata_q, vec_q} <= '0;
      {doe_q, intr_q} <= '0;
    end
    else if (ce)
    begin
      pre_q      <= tick2m ? '0 : pre_q + 5'h01;
      out_prev_q <= ctr_out;
      if (io_wr_stb && sel_par)
        par_q <= io_wdata;
      if (io_rd_stb && rd_hit)
        rdata_q <= rdata_d;
      doe_q  <= io_rd_stb & rd_hit;
      intr_q <= interrupt_enable_jumper & ctr_out[NUM_CTR-1];
      vec_q  <= {vec_absent, 1'b0};
    end
  end

  chk_par_latch: assert property (@(posedge clk_sys) disable iff (srst)
    (ce && io_wr_stb && sel_par) |=> par_out == $past(io_wdata))
    else $error("parallel latch missed a write");
  chk_doe_read: assert property (@(posedge clk_sys) disable iff (srst)
    (io_doe && $past(ce)) |-> $past(io_rd_stb && rd_hit))
    else $error("bus driven outside a decoded read");
  chk_base_miss: assert property (@(posedge clk_sys) disable iff (srst)
    (ce && io_rd_stb && !hit_base) |=> !io_doe)
    else $error("answered off the jumpered base");
  chk_vec_form: assert property (@(posedge clk_sys) disable iff (srst)
    ($past(ce) && !$past(srst)) |-> intr_vector == {$past(vec_absent), 1'b0})
    else $error("vector not taken from jumpers with bit 0 low");
  chk_intr_gate: assert property (@(posedge clk_sys) disable iff (srst)
    (ce && !interrupt_enable_jumper) |=> !intr_req)
    else $error("interrupt raised with enable jumper absent");
endmodule

// ---- verif/sio_term.sv ----
`timescale 1ns/1ps

module sio_term #(
  parameter int BIT_CLK = 640
) (
  input  wire logic       clk_sys,
  input  wire logic       txd,
  output logic      [7:0] rx_byte,
  output logic            rx_got
);
  initial
  begin
    rx_byte = 8'h00;
    rx_got  = 1'b0;
    forever
    begin
      @(negedge clk_sys);
      rx_got = 1'b0;
      if (txd === 1'b0)
      begin
        // sample each bit at its centre; a low stop bit yields no byte
        repeat (BIT_CLK / 2) @(negedge clk_sys);
        for (int i = 0; i < 8; i++)
        begin
          repeat (BIT_CLK) @(negedge clk_sys);
          rx_byte[i] = txd;
        end
        repeat (BIT_CLK) @(negedge clk_sys);
        rx_got = (txd === 1'b1);
      end
    end
  end
endmodule

// ---- verif/tb_top.sv ----
`timescale 1ns/1ps

module tb_top;
  import sio_pkg::*;
  logic       clk_sys, srst, ce, io_wr_stb, io_rd_stb, io_doe, intr_req;
  logic       interrupt_enable_jumper, rtc_chain, par_in_fitted, got_l, got_c;
  logic       list_rxd, list_cts_n, list_txd, con_rxd, con_cts_n, con_txd;
  logic [7:0] io_addr, io_wdata, io_rdata, par_in, par_out, intr_vector;
  logic [7:0] byte_l, byte_c, d;
  logic [3:0] base_jumper;
  logic [6:0] vec_absent;
  logic [5:0] tmr_out;
  logic [7:0] rq[$], lq[$], cq[$];
  int         num_errors = 0;
  int         n_tests = 0;

  // console receiver listens to its own transmitter
  assign con_rxd = con_txd;

  sio_board i_dut (.clk_sys(clk_sys), .srst(srst), .ce(ce), .io_addr(io_addr),
    .io_wr_stb(io_wr_stb), .io_rd_stb(io_rd_stb), .io_wdata(io_wdata),
    .io_rdata(io_rdata), .io_doe(io_doe), .base_jumper(base_jumper),
    .vec_absent(vec_absent), .interrupt_enable_jumper(interrupt_enable_jumper),
    .rtc_chain(rtc_chain), .par_in_fitted(par_in_fitted), .par_in(par_in),
    .par_out(par_out), .list_rxd(list_rxd), .list_cts_n(list_cts_n),
    .list_txd(list_txd), .con_rxd(con_rxd), .con_cts_n(con_cts_n),
    .con_txd(con_txd), .tmr_out(tmr_out), .intr_req(intr_req),
    .intr_vector(intr_vector));
  sio_term i_term_l (.clk_sys(clk_sys), .txd(list_txd), .rx_byte(byte_l), .rx_got(got_l));
  sio_term i_term_c (.clk_sys(clk_sys), .txd(con_txd), .rx_byte(byte_c), .rx_got(got_c));

  initial
  begin
    clk_sys = 1'b0;
    forever #12.5 clk_sys = ~clk_sys;
  end

  task automatic chk(input string nm, input logic [7:0] s, input logic [7:0] e);
    n_tests++;
    if (s !== e)
    begin
      num_errors++;
      $display("BAD %s exp %h got %h", nm, e, s);
    end
  endtask

  task automatic stop_test;
    $display("comparisons %0d mismatches %0d", n_tests, num_errors);
    if (num_errors == 0 && n_tests > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    @(negedge clk_sys);
    io_addr   = a;
    io_wdata  = v;
    io_wr_stb = 1'b1;
    @(negedge clk_sys);
    io_wr_stb = 1'b0;
  endtask

  // ans low: the board must not answer at all
  task automatic rd(input logic [7:0] a, input logic [7:0] e, input bit ans);
    if (ans)
      rq.push_back(e);
    @(negedge clk_sys);
    io_addr   = a;
    io_rd_stb = 1'b1;
    @(negedge clk_sys);
    io_rd_stb = 1'b0;
    @(negedge clk_sys);
  endtask

  always @(negedge clk_sys)
    if (io_doe === 1'b1)
      chk("io_rdata", io_rdata, rq.size() != 0 ? rq.pop_front() : 8'hXX);
  always @(posedge got_l)
    chk("list_txd", byte_l, lq.size() != 0 ? lq.pop_front() : 8'hXX);
  always @(posedge got_c)
    chk("con_txd", byte_c, cq.size() != 0 ? cq.pop_front() : 8'hXX);

  initial
  begin
    {srst, ce, io_wr_stb, io_rd_stb, rtc_chain, par_in_fitted} = 6'h30;
    {io_addr, io_wdata, par_in, base_jumper, vec_absent} = {24'h000000, 4'h8, 7'h08};
    {interrupt_enable_jumper, list_rxd, list_cts_n, con_cts_n} = 4'hF;
    void'($urandom(32'hD07DF9ED));
    repeat (5) @(negedge clk_sys);
    srst = 1'b0;
    repeat (2) @(negedge clk_sys);
    chk("par_out", par_out, 8'h00);
    chk("txd", {6'h00, list_txd, con_txd}, 8'h03);
    chk("intr_vector", intr_vector, 8'h10);
    vec_absent = 7'h55;
    repeat (2) @(negedge clk_sys);
    chk("intr_vector", intr_vector, 8'hAA);
    $display("test jumpers done");

    for (int i = 0; i < 4; i++)
    begin
      d = 8'($urandom);
      wr(REG_PAR, d);
      chk("par_out", par_out, d);
    end
    par_in = 8'($urandom);
    rd(REG_PAR, 8'h00, 0);
    par_in_fitted = 1'b1;
    rd(REG_PAR, par_in, 1);
    wr(8'h9D, ~d);
    chk("par_out", par_out, d);
    base_jumper = 4'h9;
    wr(8'h9D, ~d);
    chk("par_out", par_out, ~d);
    rd(REG_PAR, 8'h00, 0);
    base_jumper = 4'h8;
    // a strobe while the clock enable is low must not land
    ce = 1'b0;
    wr(REG_PAR, d);
    chk("par_out", par_out, ~d);
    ce = 1'b1;
    $display("test parallel done");

    interrupt_enable_jumper = 1'b0;
    wr(REG_TMR_B + 8'h03, 8'h80);
    wr(REG_TMR_B + 8'h02, 8'h03);
    wr(REG_TMR_B + 8'h02, 8'h00);
    repeat (200) @(negedge clk_sys);
    chk("tmr_out5", {7'h00, tmr_out[5]}, 8'h01);
    chk("intr_req", {7'h00, intr_req}, 8'h00);
    interrupt_enable_jumper = 1'b1;
    repeat (2) @(negedge clk_sys);
    chk("intr_req", {7'h00, intr_req}, 8'h01);
    // chained counter 4 holds still while counter 3 is idle
    rtc_chain = 1'b1;
    wr(REG_TMR_B + 8'h03, 8'h40);
    wr(REG_TMR_B + 8'h01, 8'h34);
    wr(REG_TMR_B + 8'h01, 8'h12);
    rd(REG_TMR_B + 8'h01, 8'h34, 1);
    rd(REG_TMR_B + 8'h01, 8'h12, 1);
    $display("test interrupt done");

    // baud counters in square wave, BCD, count 2 for a short bit time
    wr(REG_TMR_A + 8'h03, 8'h07);
    wr(REG_TMR_A, 8'h02);
    wr(REG_TMR_A, 8'h00);
    wr(REG_TMR_A + 8'h03, 8'h47);
    wr(REG_TMR_A + 8'h01, 8'h02);
    wr(REG_TMR_A + 8'h01, 8'h00);
    wr(REG_LIST_STAT, 8'h4E);
    wr(REG_LIST_STAT, 8'h05);
    wr(REG_CON_STAT, 8'h4E);
    wr(REG_CON_STAT, 8'h05);
    rd(REG_LIST_STAT, 8'h04, 1);
    list_cts_n = 1'b0;
    rd(REG_LIST_STAT, 8'h05, 1);
    wr(8'h91, 8'h5A);
    for (int i = 0; i < 9; i++)
    begin
      d = 8'($urandom);
      lq.push_back(d);
      wr(REG_LIST_DATA, d);
    end
    rd(REG_LIST_STAT, 8'h00, 1);
    wr(REG_LIST_DATA, 8'hEE);
    list_cts_n = 1'b1;
    d = 8'($urandom);
    cq.push_back(d);
    wr(REG_CON_DATA, d);
    repeat (2000) @(negedge clk_sys);
    chk("con_txd", {7'h00, con_txd}, 8'h01);
    list_cts_n = 1'b0;
    con_cts_n  = 1'b0;
    for (int i = 0; i < 80000 && lq.size() + cq.size() != 0; i++)
      @(negedge clk_sys);
    chk("pending", 8'(lq.size() + cq.size()), 8'h00);
    if (lq.size() + cq.size() == 0)
    begin
      // short low pulse on the list line is a false start
      list_rxd = 1'b0;
      repeat (100) @(negedge clk_sys);
      list_rxd = 1'b1;
      repeat (600) @(negedge clk_sys);
      rd(REG_CON_DATA, d, 1);
      rd(REG_CON_STAT, 8'h05, 1);
      rd(REG_LIST_STAT, 8'h05, 1);
      // two bytes left unread: the second overruns the first
      for (int i = 0; i < 2; i++)
      begin
        d = 8'($urandom);
        cq.push_back(d);
        wr(REG_CON_DATA, d);
      end
      for (int i = 0; i < 20000 && cq.size() != 0; i++)
        @(negedge clk_sys);
      repeat (700) @(negedge clk_sys);
      rd(REG_CON_STAT, 8'h17, 1);
      rd(REG_CON_DATA, d, 1);
      wr(REG_CON_STAT, 8'h15);
      rd(REG_CON_STAT, 8'h05, 1);
      chk("pending_rd", 8'(rq.size() + cq.size()), 8'h00);
      $display("test serial done");
    end
    stop_test();
  end
endmodule
